// *** src/selftest_ctrl.sv ***
// Purpose: Power-up test sequencing, lamp driving and switch decode
// Assumes: Test routines answer test_done/test_fail; inputs synchronous to clk
// Notes:   One APB wait state on every access
//
// Local design decisions: the address map and the APB slave port.
module selftest_ctrl #(
  parameter int NUM_TESTS = selftest_pkg::NUM_TESTS_DFLT,
  parameter int FLASH_HALF_CYC = selftest_pkg::FLASH_HALF_CYC,
  parameter int FLASH_LIMIT = selftest_pkg::FLASH_LIMIT_HALVES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [selftest_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [7:0] sw_level,
  input wire logic init_req,
  input wire logic test_done,
  input wire logic test_fail,
  output logic test_start,
  output logic [3:0] test_code,
  input wire logic err_valid,
  input wire logic [3:0] err_class,
  input wire logic err_unit,
  input wire logic err_density,
  input wire logic [1:0] head_loaded,
  output logic [1:0] activity_led,
  output logic [8:0] led,
  output logic normal_mode,
  output logic standalone_diagnostic_mode,
  output logic [7:0] diag_select,
  output logic legacy_mode,
  output logic mode3,
  output logic drive_swap,
  output logic double_sided,
  output logic two_drives
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (NUM_TESTS < 1 || NUM_TESTS > 15 || FLASH_HALF_CYC < 1 || FLASH_LIMIT < 1 || FLASH_LIMIT > 65535) begin : g_bad
      $error("selftest_ctrl: parameter out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lamp 5 carries the MSB, lamp 8 the LSB
  function automatic logic [3:0] lamp_field(input logic [3:0] c);
    lamp_field = {c[0], c[1], c[2], c[3]};
  endfunction : lamp_field

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int EV_W_L = selftest_pkg::EV_W;
  selftest_pkg::state_t state_r, state_nxt;
  logic [3:0] code_r, code_nxt;
  logic [7:0] sw_r;
  logic [3:0] class_r, class_nxt;
  logic [8:0] led_r, led_nxt;
  logic test_start_r;
  logic normal_r, diag_r;
  logic legacy_r, mode3_r, swap_r, dsided_r, two_r;
  logic [1:0] flash_r, flash_nxt;
  logic [31:0] cnt_r;
  logic [15:0] halves_r;
  logic phase_r;
  logic [1:0] act_r;
  logic [EV_W_L-1:0] ev_r, ev_nxt, ev_set, ev_clr;
  logic [EV_W_L-1:0] mask_r;
  logic [7:0] diag_lamps_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire last_test = (code_r == 4'(NUM_TESTS));
  wire err_take = (state_r == selftest_pkg::ST_NORMAL) && err_valid && !init_req;
  wire init_take = (state_r == selftest_pkg::ST_NORMAL) && init_req;
  wire normal_sel = (sw_r[2:0] == 3'h0);
  wire fail_now = (state_r == selftest_pkg::ST_WAIT) && test_done && test_fail;
  wire pass_all = (state_r == selftest_pkg::ST_WAIT) && test_done && !test_fail && last_test;

  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    case (state_r)
      selftest_pkg::ST_SAMPLE: begin
        state_nxt = selftest_pkg::ST_LOAD;
        code_nxt = 4'h1;
      end
      selftest_pkg::ST_LOAD: state_nxt = selftest_pkg::ST_RUN;
      selftest_pkg::ST_RUN: state_nxt = selftest_pkg::ST_WAIT;
      selftest_pkg::ST_WAIT: begin
        if (test_done) begin
          if (test_fail) begin
            state_nxt = selftest_pkg::ST_HALT;
          end else if (last_test) begin
            state_nxt = selftest_pkg::ST_SEL;
          end else begin
            state_nxt = selftest_pkg::ST_LOAD;
            code_nxt = code_r + 4'h1;
          end
        end
      end
      selftest_pkg::ST_SEL: begin
        state_nxt = normal_sel ? selftest_pkg::ST_NORMAL : selftest_pkg::ST_DIAG;
      end
      selftest_pkg::ST_NORMAL: begin
        if (init_req) begin
          state_nxt = selftest_pkg::ST_LOAD;
          code_nxt = 4'h1;
        end
      end
      selftest_pkg::ST_DIAG: state_nxt = selftest_pkg::ST_DIAG;
      selftest_pkg::ST_HALT: state_nxt = selftest_pkg::ST_HALT;
      default: state_nxt = selftest_pkg::ST_SAMPLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= selftest_pkg::ST_SAMPLE;
      code_r <= 4'h0;
      test_start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      test_start_r <= (state_r == selftest_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Switch capture and decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_r <= 8'h00;
      legacy_r <= 1'b0;
      mode3_r <= 1'b0;
      swap_r <= 1'b0;
      dsided_r <= 1'b0;
      two_r <= 1'b0;
    end else if (state_r == selftest_pkg::ST_SAMPLE) begin
      sw_r <= sw_level;
      legacy_r <= sw_level[3];
      swap_r <= sw_level[4];
      dsided_r <= sw_level[5];
      mode3_r <= sw_level[6];
      two_r <= sw_level[7];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      normal_r <= 1'b0;
      diag_r <= 1'b0;
    end else begin
      normal_r <= (state_nxt == selftest_pkg::ST_NORMAL);
      diag_r <= (state_nxt == selftest_pkg::ST_DIAG);
    end
  end

  // ----------------------------------------------------------------
  // Error class and lamps
  // ----------------------------------------------------------------
  assign class_nxt = init_take ? 4'h0 : (err_take ? err_class : class_r);

  always_comb begin
    case (state_r)
      selftest_pkg::ST_HALT: led_nxt = {1'b0, lamp_field(code_r), 4'b0010};
      selftest_pkg::ST_NORMAL: led_nxt = {1'b1, lamp_field(class_nxt), 4'b0000};
      selftest_pkg::ST_DIAG: led_nxt = {1'b1, diag_lamps_r};
      default: led_nxt = {1'b1, lamp_field(code_r), 4'b0000};
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      class_r <= 4'h0;
      led_r <= selftest_pkg::LED_RST;
    end else begin
      class_r <= class_nxt;
      led_r <= led_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Activity lamp flashing
  // ----------------------------------------------------------------
  wire half_tick = (cnt_r == 32'(FLASH_HALF_CYC - 1));
  wire flash_tmo = (|flash_r) && half_tick && (halves_r == 16'(FLASH_LIMIT - 1));
  wire flash_start = err_take && !err_density;
  wire err_phys = err_unit ^ swap_r;

  always_comb begin
    flash_nxt = flash_r;
    if (init_take || flash_tmo) begin
      flash_nxt = 2'b00;
    end
    if (flash_start) begin
      flash_nxt[err_phys] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_r <= 2'b00;
      cnt_r <= 32'h0000_0000;
      halves_r <= 16'h0000;
      phase_r <= 1'b0;
    end else begin
      flash_r <= flash_nxt;
      cnt_r <= half_tick ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      phase_r <= half_tick ? ~phase_r : phase_r;
      if (flash_start || flash_nxt == 2'b00) begin
        halves_r <= 16'h0000;
      end else if (half_tick) begin
        halves_r <= halves_r + 16'h0001;
      end
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_act
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          act_r[i] <= 1'b0;
        end else begin
          act_r[i] <= flash_r[i] ? phase_r : head_loaded[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire fetch = acc && !pready_r;
  wire done = acc && pready_r;
  wire hit_status = (paddr == selftest_pkg::OFS_STATUS);
  wire hit_config = (paddr == selftest_pkg::OFS_CONFIG);
  wire hit_event = (paddr == selftest_pkg::OFS_EVENT);
  wire hit_mask = (paddr == selftest_pkg::OFS_MASK);
  wire hit_lamps = (paddr == selftest_pkg::OFS_DIAG_LAMPS);
  wire hit_any = hit_status | hit_config | hit_event | hit_mask | hit_lamps;
  wire wr_mask = done && pwrite && hit_mask;
  wire wr_lamps = done && pwrite && hit_lamps;

  wire [31:0] status_word = {16'h0000, 2'b00, flash_r, class_r, code_r, diag_r, normal_r,
                             (state_r == selftest_pkg::ST_HALT), (state_r != selftest_pkg::ST_HALT)};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_config ? {24'h00_0000, sw_r} :
                       hit_event ? {28'h000_0000, ev_r} :
                       hit_mask ? {28'h000_0000, mask_r} :
                       hit_lamps ? {24'h00_0000, diag_lamps_r} : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= fetch;
      pslverr_r <= fetch && !hit_any;
      prdata_r <= (fetch && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= selftest_pkg::MASK_RST;
      diag_lamps_r <= selftest_pkg::DIAG_LAMPS_RST;
    end else begin
      if (wr_mask) begin
        mask_r <= pwdata[EV_W_L-1:0];
      end
      if (wr_lamps) begin
        diag_lamps_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[selftest_pkg::EV_TEST_FAIL] = fail_now;
    ev_set[selftest_pkg::EV_ERROR] = err_take;
    ev_set[selftest_pkg::EV_TEST_PASS] = pass_all;
    ev_set[selftest_pkg::EV_FLASH_TMO] = flash_tmo;
  end

  // Clear only the bits reported, so an event landing mid-read is kept
  assign ev_clr = (done && !pwrite && hit_event) ? prdata_r[EV_W_L-1:0] : '0;
  assign ev_nxt = (ev_r & ~ev_clr) | ev_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ev_r <= ev_nxt;
      irq_r <= |(ev_nxt & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign test_start = test_start_r;
  assign test_code = code_r;
  assign activity_led = act_r;
  assign led = led_r;
  assign normal_mode = normal_r;
  assign standalone_diagnostic_mode = diag_r;
  assign diag_select = sw_r;
  assign legacy_mode = legacy_r;
  assign mode3 = mode3_r;
  assign drive_swap = swap_r;
  assign double_sided = dsided_r;
  assign two_drives = two_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_code_then_start;
    (led_r[7:4] == lamp_field(code_r)) ##1 test_start_r;
  endsequence

  sequence s_halt_lamps;
    (led_r[8] == 1'b0) && (led_r[3:0] == 4'b0010) && (led_r[7:4] == lamp_field(code_r));
  endsequence

  chk_selftest_first: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_SAMPLE |=> state_r == selftest_pkg::ST_LOAD && code_r == 4'h1)
    else $error("self-test not started after reset");

  chk_code_before_test: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_LOAD |=> s_code_then_start)
    else $error("test started without its failure code shown");

  chk_halt_sticky: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_HALT |=> state_r == selftest_pkg::ST_HALT && !normal_r)
    else $error("halt state left");

  chk_halt_lamps: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_HALT |=> s_halt_lamps)
    else $error("halt lamp pattern wrong");

  chk_run_lamp: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> led_r[8] == ($past(state_r) != selftest_pkg::ST_HALT))
    else $error("run lamp does not follow run state");

  chk_normal_gate: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_SEL |=> normal_r == (sw_r[2:0] == 3'h0) && diag_r == (sw_r[2:0] != 3'h0))
    else $error("normal/diagnostic choice wrong");

  chk_diag_hold: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_DIAG |=> (state_r == selftest_pkg::ST_DIAG) [*2])
    else $error("diagnostic mode left");

  chk_cfg_decode: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_SEL |-> legacy_r == sw_r[3] && swap_r == sw_r[4] && dsided_r == sw_r[5]
      && mode3_r == sw_r[6] && two_r == sw_r[7])
    else $error("switch decode wrong");

  chk_switch_hold: assert property (@(posedge clk) disable iff (rst)
    state_r != selftest_pkg::ST_SAMPLE |=> $stable(sw_r))
    else $error("switch capture changed");

  chk_class_lamps: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_NORMAL && err_valid && !init_req |=> led_r[7:4] == lamp_field($past(err_class)))
    else $error("error class not shown at once");

  chk_class_clear: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_NORMAL && init_req |=> class_r == 4'h0 && flash_r == 2'b00)
    else $error("initialize did not clear class and flashing");

  chk_flash_start: assert property (@(posedge clk) disable iff (rst)
    state_r == selftest_pkg::ST_NORMAL && err_valid && !init_req && !err_density
      |=> flash_r[$past(err_unit ^ swap_r)])
    else $error("flashing not started on error");

endmodule : selftest_ctrl

// *** shared/selftest_pkg.sv ***
// Purpose: Constants, register map and state type for the self-test controller
// Assumes: 50 MHz clock, APB register access with 32-bit data
// Notes:   Switch bit n-1 holds switch n; lamp bit n-1 holds lamp n
//
// Summary of operation
// - Self-test always runs after reset, and after initialize in normal mode
// - Failed test halts forever, code kept shown
// - Failure code loaded on lamps before test
// - Halted: lamps 1,3,4,9 off, 2 on
// - Run lamp lit while running, dark halted
// - Open switch reads 1, closed reads 0
// - Normal only when switches 1-3 closed
// - Diagnostic selection fixed and runs until power-off
// - Switch 4 picks legacy or extended family
// - Switch 5 swaps drive to unit mapping
// - Switch 6 selects single or double sided
// - Switch 7 picks extended format mode
// - Switch 8 selects one or two drives
// - Normal mode lamps 5-8 show error class
// - Activity lamp: head loaded, flashes after non-density error
// - Lamp 5 is class MSB, lamp 8 LSB
// - Class updates at once, clears on init
package selftest_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int FLASH_PERIOD_MS = 1000;
  localparam int FLASH_TIMEOUT_S = 120;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_PERIOD_MS / 2;
  localparam int FLASH_LIMIT_HALVES = FLASH_TIMEOUT_S * 1000 * 2 / FLASH_PERIOD_MS;
  localparam int NUM_TESTS_DFLT = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h000;
  localparam logic [APB_AW-1:0] OFS_CONFIG = 12'h004;
  localparam logic [APB_AW-1:0] OFS_EVENT = 12'h008;
  localparam logic [APB_AW-1:0] OFS_MASK = 12'h00c;
  localparam logic [APB_AW-1:0] OFS_DIAG_LAMPS = 12'h010;

  // Status fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_HALT_BIT = 1;
  localparam int ST_NORMAL_BIT = 2;
  localparam int ST_DIAG_BIT = 3;
  localparam int ST_CODE_LSB = 4;
  localparam int ST_CLASS_LSB = 8;
  localparam int ST_FLASH_LSB = 12;

  // Event fields
  localparam int EV_W = 4;
  localparam int EV_TEST_FAIL = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_TEST_PASS = 2;
  localparam int EV_FLASH_TMO = 3;

  // Reset values
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [7:0] DIAG_LAMPS_RST = 8'h00;
  localparam logic [8:0] LED_RST = 9'h000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_LOAD,
    ST_RUN,
    ST_WAIT,
    ST_SEL,
    ST_NORMAL,
    ST_DIAG,
    ST_HALT
  } state_t;

endpackage : selftest_pkg

// *** tb/sw_lamp_model.sv ***
// Purpose: Switch bank and lamp panel facing the self-test block
// Assumes: Operator moves switches only while power is off (reset held)
// Notes:   Misuse lets one scenario move switches with power on
module sw_lamp_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic misuse,
  input wire logic [7:0] sw_set,
  output logic [7:0] sw_level,
  input wire logic [8:0] led,
  output logic run_lit,
  output logic [3:0] class_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Switch bank
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || misuse) begin
      sw_level <= sw_set;
    end
  end

  // ----------------------------------------------------------------
  // Lamp reading
  // ----------------------------------------------------------------
  assign run_lit = led[8];
  assign class_seen = {led[4], led[5], led[6], led[7]};
endmodule : sw_lamp_model

// *** tb/selftest_status_and_switch_decode_tb_top.sv ***
// Purpose: Self-checking bench for the self-test block
// Assumes: Short flash timing and three power-up tests
// Notes:   Inputs driven at rising edge; APB answer taken at rising edge
module selftest_status_and_switch_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NT = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, test_start, normal_mode, standalone_diagnostic_mode;
  logic legacy_mode, mode3, drive_swap, double_sided, two_drives, run_lit, misuse = 1'b0;
  logic init_req = 1'b0, test_done = 1'b0, test_fail = 1'b0, err_valid = 1'b0;
  logic err_unit = 1'b0, err_density = 1'b0;
  logic [3:0] err_class = 4'h0, test_code, class_seen;
  logic [1:0] head_loaded = 2'h0, activity_led;
  logic [8:0] led;
  logic [7:0] sw_level, sw_set = 8'h00, diag_select;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  selftest_ctrl #(.NUM_TESTS(NT), .FLASH_HALF_CYC(4), .FLASH_LIMIT(3)) selftest_ctrl_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sw_level(sw_level), .init_req(init_req), .test_done(test_done), .test_fail(test_fail),
    .test_start(test_start), .test_code(test_code), .err_valid(err_valid), .err_class(err_class),
    .err_unit(err_unit), .err_density(err_density), .head_loaded(head_loaded),
    .activity_led(activity_led), .led(led), .normal_mode(normal_mode),
    .standalone_diagnostic_mode(standalone_diagnostic_mode), .diag_select(diag_select),
    .legacy_mode(legacy_mode), .mode3(mode3), .drive_swap(drive_swap),
    .double_sided(double_sided), .two_drives(two_drives));

  sw_lamp_model sw_lamp_model_i (.clk(clk), .rst(rst), .misuse(misuse), .sw_set(sw_set),
    .sw_level(sw_level), .led(led), .run_lit(run_lit), .class_seen(class_seen));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp);
    check(e, 1'b0);
  endtask : rd_chk

  task automatic pwr_up(input logic [7:0] sw);
    @(posedge clk);
    sw_set <= sw;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : pwr_up

  task automatic pulse_err(input logic [3:0] cls, input logic unit, input logic dens);
    @(posedge clk);
    err_valid <= 1'b1;
    err_class <= cls;
    err_unit <= unit;
    err_density <= dens;
    @(posedge clk);
    err_valid <= 1'b0;
    @(negedge clk);
  endtask : pulse_err

  task automatic pulse_init();
    @(posedge clk);
    init_req <= 1'b1;
    @(posedge clk);
    init_req <= 1'b0;
    @(negedge clk);
  endtask : pulse_init

  task automatic run_tests(input int fail_at);
    int n;
    for (int k = 1; k <= NT; k++) begin
      n = 0;
      @(negedge clk);
      while (test_start !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      check(test_code, k);
      check(class_seen, k);
      check(run_lit, 1'b1);
      @(posedge clk);
      test_done <= 1'b1;
      test_fail <= (k == fail_at);
      @(posedge clk);
      test_done <= 1'b0;
      test_fail <= 1'b0;
      if (k == fail_at) break;
    end
    repeat (3) @(negedge clk);
  endtask : run_tests

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic e;
    int cnt;
    pwr_up(8'ha8);
    run_tests(0);
    check(normal_mode, 1'b1);
    check({legacy_mode, drive_swap, double_sided, mode3, two_drives}, 5'b10101);
    check(led[3:0], 4'h0);
    rd_chk(selftest_pkg::OFS_CONFIG, 32'h0000_00a8);
    rd_chk(selftest_pkg::OFS_EVENT, 32'h0000_0004);
    rd_chk(selftest_pkg::OFS_EVENT, 32'h0000_0000);
    apb(1'b1, selftest_pkg::OFS_MASK, 32'h0000_0002, d, e);
    rd_chk(selftest_pkg::OFS_MASK, 32'h0000_0002);
    apb(1'b0, 12'h020, 32'h0, d, e);
    check(e, 1'b1);
    @(posedge clk);
    misuse <= 1'b1;
    sw_set <= 8'h57;
    repeat (2) @(posedge clk);
    misuse <= 1'b0;
    repeat (2) @(negedge clk);
    check({normal_mode, legacy_mode, drive_swap, double_sided, mode3, two_drives}, 6'b110101);
    pulse_err(4'hb, 1'b0, 1'b0);
    check(class_seen, 4'hb);
    check(irq, 1'b1);
    cnt = 0;
    repeat (30) begin
      @(negedge clk);
      cnt += int'(activity_led[0] === 1'b1);
    end
    check(cnt != 0, 1'b1);
    check(activity_led, 2'b00);
    rd_chk(selftest_pkg::OFS_EVENT, 32'h0000_000a);
    @(negedge clk);
    check(irq, 1'b0);
    @(posedge clk);
    head_loaded <= 2'b10;
    pulse_err(4'h2, 1'b1, 1'b1);
    check(class_seen, 4'h2);
    cnt = 0;
    repeat (20) begin
      @(negedge clk);
      cnt += int'(activity_led !== 2'b10);
    end
    check(cnt, 0);
    pulse_init();
    check(class_seen, 4'h0);
    run_tests(0);
    check(normal_mode, 1'b1);
    pwr_up(8'h21);
    run_tests(0);
    check({standalone_diagnostic_mode, normal_mode, double_sided}, 3'b101);
    check(diag_select, 8'h21);
    apb(1'b1, selftest_pkg::OFS_DIAG_LAMPS, 32'h0000_005a, d, e);
    repeat (2) @(negedge clk);
    check(led[7:0], 8'h5a);
    pwr_up(8'h00);
    run_tests(2);
    check(led, 9'h042);
    rd_chk(selftest_pkg::OFS_STATUS, 32'h0000_0022);
    pulse_init();
    pulse_err(4'h7, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    check({normal_mode, led}, {1'b0, 9'h042});
    wrap_up();
  end
endmodule : selftest_status_and_switch_decode_tb_top
